// File: crc_cfg.svh
/*
 * Constants for the byte-wide CRC-16 generator: register offsets, reset values,
 * generator constants and bit counts.
 * Assumes it is included by bare name; the guard keeps repeated inclusion harmless.
 */
`ifndef CRC_CFG_SVH
`define CRC_CFG_SVH

`define CRC_OFS_GEN_SELECT      32'h0000_0000
`define CRC_OFS_BYTE_INPUT      32'h0000_0004
`define CRC_OFS_SUM_LOW         32'h0000_0008
`define CRC_OFS_SUM_HIGH        32'h0000_000C

`define CRC_GENERATOR_CHOICE_CCITT          16'h1021
`define CRC_GENERATOR_CHOICE_CRC16          16'h8005

`define CRC_RST_GEN_SELECT      1'b0
`define CRC_RST_BYTE            8'h00
`define CRC_RST_SUM             16'h0000

`define CRC_GEN_SEL_BIT         0
`define CRC_BITS_PER_BYTE       8
`define CRC_SUM_MSB             15
`define CRC_ZERO_BYTE           8'h00
`define CRC_ZERO_WORD           32'h0000_0000
`define CRC_ZERO_UPPER          24'h00_0000
`define CRC_ZERO_CTRL_PAD       7'h00
`define CRC_HRESP_OKAY          1'b0

`endif

// File: crc_pkg.sv
/*
 * Types and the shared address decoder of the CRC-16 generator.
 * Assumes crc_cfg.svh is available on the include path.
 */
`include "crc_cfg.svh"

package crc_pkg;

    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_GEN,
        SEL_IN,
        SEL_LOW,
        SEL_HIGH
    } reg_sel_t;

    typedef enum logic {
        GEN_CCITT,
        GEN_CRC16
    } generator_choice_t;

    // Unmapped addresses decode to SEL_NONE: reads give zero, writes are dropped
    function automatic reg_sel_t decode_addr(input logic [31:0] addr);
        reg_sel_t sel;
        sel = SEL_NONE;
        if (addr == `CRC_OFS_GEN_SELECT)
            sel = SEL_GEN;
        else if (addr == `CRC_OFS_BYTE_INPUT)
            sel = SEL_IN;
        else if (addr == `CRC_OFS_SUM_LOW)
            sel = SEL_LOW;
        else if (addr == `CRC_OFS_SUM_HIGH)
            sel = SEL_HIGH;
        return sel;
    endfunction

endpackage

// File: crc_byte_engine.sv
/*
 * Combinational fold of one byte into a 16-bit running checksum, MSB first.
 * Assumes the caller registers the result; the whole byte settles in one cycle.
 */
`timescale 1ns/100ps
`include "crc_cfg.svh"

module crc_byte_engine
    import crc_pkg::*;
(
    input  wire logic [15:0]       sum_in,     // Checksum before the byte
    input  wire logic [7:0]        data_in,    // Byte to fold in
    input  wire generator_choice_t gen_choice, // Generator in force
    output logic      [15:0]       sum_out     // Checksum after the byte
);

    logic [15:0] stage [0:`CRC_BITS_PER_BYTE];
    logic [15:0] xor_const;

    // Only the two fixed constants exist; there is no programmable generator
    assign xor_const = (gen_choice == GEN_CRC16) ? `CRC_GENERATOR_CHOICE_CRC16 : `CRC_GENERATOR_CHOICE_CCITT;

    assign stage[0] = sum_in ^ {data_in, `CRC_ZERO_BYTE};

    genvar i;
    generate
        for (i = 0; i < `CRC_BITS_PER_BYTE; i++)
        begin : g_bit
            logic [15:0] shifted;
            assign shifted      = {stage[i][14:0], 1'b0};
            assign stage[i + 1] = stage[i][`CRC_SUM_MSB] ? (shifted ^ xor_const) : shifted;
        end
    endgenerate

    assign sum_out = stage[`CRC_BITS_PER_BYTE];

endmodule

// File: ahb_addr_stage.sv
/*
 * AHB-Lite address-phase capture for the CRC register slave.
 * Assumes a single master and zero-wait answers, so every accepted address
 * phase is followed by exactly one data phase in the next cycle.
 */
`timescale 1ns/100ps
`include "crc_cfg.svh"

module ahb_addr_stage
    import crc_pkg::*;
(
    input  wire logic        clk_sys,   // System clock
    input  wire logic        resetn,    // Asynchronous reset, active low
    input  wire logic        clk_en,    // Freezes state while low
    input  wire logic        hsel,      // Slave select
    input  wire logic [1:0]  htrans,    // Transfer type
    input  wire logic        hwrite,    // Write when high
    input  wire logic [31:0] haddr,     // Byte address
    input  wire logic        hready,    // Bus ready
    output logic             ph_write,  // Data phase of a write pending
    output reg_sel_t         ph_sel     // Register addressed by that write
);

    logic accept;

    // NONSEQ and SEQ both carry htrans[1]; IDLE and BUSY are ignored
    assign accept = hsel && htrans[1] && hready;

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            ph_write <= 1'b0;
            ph_sel   <= SEL_NONE;
        end
        else if (clk_en)
        begin
            ph_write <= accept && hwrite;
            ph_sel   <= accept ? decode_addr(haddr) : SEL_NONE;
        end
    end

endmodule

// File: byte_crc16_generator.sv
/*
 * Byte-wide CRC-16 generator with an AHB-Lite register slave: generator
 * select, byte input and the two checksum bytes.
 * Assumes one AHB-Lite master issuing single word transfers, a 25 MHz clk_sys
 * and a clock enable that freezes every flip-flop while low.
 */
// The implementer's own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/100ps
`include "crc_cfg.svh"

module byte_crc16_generator
    import crc_pkg::*;
(
    input  wire logic        clk_sys,    // System clock, 25 MHz
    input  wire logic        resetn,     // Asynchronous reset, active low
    input  wire logic        clk_en,     // Freezes all state while low
    input  wire logic        hsel,       // AHB slave select
    input  wire logic [31:0] haddr,      // AHB byte address
    input  wire logic [1:0]  htrans,     // AHB transfer type
    input  wire logic        hwrite,     // AHB write
    input  wire logic [2:0]  hsize,      // AHB size, word only
    input  wire logic [31:0] hwdata,     // AHB write data
    input  wire logic        hready,     // AHB bus ready
    output logic [31:0]      hrdata,     // AHB read data
    output logic             hreadyout,  // AHB slave ready
    output logic             hresp       // AHB response, always OKAY
);

    generator_choice_t generator_choice;
    logic [7:0]        crc_byte_input;
    logic [15:0]       running_checksum;

    generator_choice_t next_generator_choice;
    logic [7:0]        next_crc_byte_input;
    logic [15:0]       next_running_checksum;

    logic              ph_write;
    reg_sel_t          ph_sel;
    logic [15:0]       folded_sum;
    logic              read_accept;
    reg_sel_t          read_sel;
    logic [7:0]        wr_byte;

    logic unused_size;
    assign unused_size = ^hsize;

    assign wr_byte     = hwdata[7:0];
    assign read_accept = hsel && htrans[1] && hready && !hwrite;
    assign read_sel    = decode_addr(haddr);

    ahb_addr_stage u_addr_stage (
        .clk_sys  (clk_sys),
        .resetn   (resetn),
        .clk_en   (clk_en),
        .hsel     (hsel),
        .htrans   (htrans),
        .hwrite   (hwrite),
        .haddr    (haddr),
        .hready   (hready),
        .ph_write (ph_write),
        .ph_sel   (ph_sel)
    );

    // Folds against the generator already stored, never the one being written
    crc_byte_engine u_engine (
        .sum_in     (running_checksum),
        .data_in    (wr_byte),
        .gen_choice (generator_choice),
        .sum_out    (folded_sum)
    );

    function automatic logic [7:0] read_byte(
        input reg_sel_t          sel,
        input generator_choice_t gen,
        input logic [7:0]        in_byte,
        input logic [15:0]       sum
    );
        logic [7:0] value;
        value = `CRC_ZERO_BYTE;
        if (sel == SEL_GEN)
            value = {`CRC_ZERO_CTRL_PAD, gen == GEN_CRC16};
        else if (sel == SEL_IN)
            value = in_byte;
        else if (sel == SEL_LOW)
            value = sum[7:0];
        else if (sel == SEL_HIGH)
            value = sum[15:8];
        return value;
    endfunction

    always_comb
    begin
        next_generator_choice = generator_choice;
        if (ph_write && ph_sel == SEL_GEN)
            next_generator_choice = wr_byte[`CRC_GEN_SEL_BIT] ? GEN_CRC16 : GEN_CCITT;
    end

    always_comb
    begin
        next_crc_byte_input = crc_byte_input;
        if (ph_write && ph_sel == SEL_IN)
            next_crc_byte_input = wr_byte;
    end

    always_comb
    begin
        next_running_checksum = running_checksum;
        if (ph_write && ph_sel == SEL_IN)
            next_running_checksum = folded_sum;
        else if (ph_write && ph_sel == SEL_LOW)
            next_running_checksum = {running_checksum[15:8], wr_byte};
        else if (ph_write && ph_sel == SEL_HIGH)
            next_running_checksum = {wr_byte, running_checksum[7:0]};
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            generator_choice <= GEN_CCITT;
        else if (clk_en)
            generator_choice <= next_generator_choice;
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            crc_byte_input <= `CRC_RST_BYTE;
        else if (clk_en)
            crc_byte_input <= next_crc_byte_input;
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            running_checksum <= `CRC_RST_SUM;
        else if (clk_en)
            running_checksum <= next_running_checksum;
    end

    // Read data is taken from the next values so a read right behind a write
    // sees that write; this keeps the slave zero-wait without a stall cycle
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            hrdata <= `CRC_ZERO_WORD;
        else if (clk_en && read_accept)
            hrdata <= {`CRC_ZERO_UPPER, read_byte(read_sel, next_generator_choice,
                                                  next_crc_byte_input,
                                                  next_running_checksum)};
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            hreadyout <= 1'b1;
            hresp     <= `CRC_HRESP_OKAY;
        end
        else if (clk_en)
        begin
            hreadyout <= 1'b1;
            hresp     <= `CRC_HRESP_OKAY;
        end
    end

    // Bit-serial reference, written apart from the engine, for the checks below
    function automatic logic [15:0] crc_ref(
        input logic [15:0] sum,
        input logic [7:0]  data,
        input logic        use_crc16
    );
        logic [15:0] t;
        logic        top;
        t = sum;
        top = 1'b0;
        for (int k = 7; k >= 0; k--)
        begin
            top = t[15] ^ data[k];
            t = {t[14:0], 1'b0};
            if (top)
                t = t ^ (use_crc16 ? `CRC_GENERATOR_CHOICE_CRC16 : `CRC_GENERATOR_CHOICE_CCITT);
        end
        return t;
    endfunction

    logic wr_in;
    logic wr_gen;
    logic wr_low;
    logic wr_high;
    logic rd_gen_pending;
    logic rd_sum_low_next;
    logic rd_sum_high_next;
    logic rd_in_next;
    logic rd_none_next;

    assign wr_in   = clk_en && ph_write && ph_sel == SEL_IN;
    assign wr_gen  = clk_en && ph_write && ph_sel == SEL_GEN;
    assign wr_low  = clk_en && ph_write && ph_sel == SEL_LOW;
    assign wr_high = clk_en && ph_write && ph_sel == SEL_HIGH;

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            rd_gen_pending   <= 1'b0;
            rd_sum_low_next  <= 1'b0;
            rd_sum_high_next <= 1'b0;
            rd_in_next       <= 1'b0;
            rd_none_next     <= 1'b0;
        end
        else if (clk_en)
        begin
            rd_gen_pending   <= read_accept && read_sel == SEL_GEN;
            rd_sum_low_next  <= read_accept && read_sel == SEL_LOW;
            rd_sum_high_next <= read_accept && read_sel == SEL_HIGH;
            rd_in_next       <= read_accept && read_sel == SEL_IN;
            rd_none_next     <= read_accept && read_sel == SEL_NONE;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    AST_GEN_SELECT_LOAD: assert property (
        wr_gen |=> (generator_choice == GEN_CRC16) == $past(hwdata[0]))
        else $error("generator select did not follow bit 0 of the write");

    AST_CTRL_UPPER_ZERO: assert property (
        rd_gen_pending |-> hrdata[7:1] == `CRC_ZERO_CTRL_PAD)
        else $error("unimplemented select bits did not read as zero");

    AST_FOLD_MATCHES_REF: assert property (
        wr_in |=> running_checksum == crc_ref($past(running_checksum), $past(hwdata[7:0]),
                                              $past(generator_choice == GEN_CRC16)))
        else $error("checksum after a byte write differs from the reference");

    AST_READ_SEES_NEW_SUM: assert property (
        wr_in && read_accept && read_sel == SEL_LOW
        |=> hrdata[7:0] == running_checksum[7:0])
        else $error("read behind a byte write returned a stale checksum");

    AST_SINGLE_ONE_GIVES_CONST: assert property (
        wr_in && running_checksum == `CRC_RST_SUM && hwdata[7:0] == 8'h01
        |=> running_checksum == ($past(generator_choice == GEN_CRC16) ?
                                 `CRC_GENERATOR_CHOICE_CRC16 : `CRC_GENERATOR_CHOICE_CCITT))
        else $error("byte 01 from zero seed did not give the generator constant");

    AST_HIGH_BYTE_XOR: assert property (
        wr_in && running_checksum[15:8] == hwdata[7:0] && running_checksum[7:0] == 8'h00
        |=> running_checksum == `CRC_RST_SUM)
        else $error("byte equal to the high checksum byte did not cancel");

    AST_LOAD_LOW_DIRECT: assert property (
        wr_low |=> running_checksum == {$past(running_checksum[15:8]), $past(hwdata[7:0])})
        else $error("low checksum write did not load directly");

    AST_LOAD_HIGH_DIRECT: assert property (
        wr_high |=> running_checksum == {$past(hwdata[7:0]), $past(running_checksum[7:0])})
        else $error("high checksum write did not load directly");

    AST_INPUT_READBACK: assert property (
        wr_in |=> crc_byte_input == $past(hwdata[7:0]))
        else $error("input register did not keep the last byte");

    AST_SELECT_KEEPS_SUM: assert property (
        wr_gen |=> $stable(running_checksum))
        else $error("generator change altered the checksum");

    AST_IDLE_HOLDS_SUM: assert property (
        !(wr_in || wr_low || wr_high) |=> $stable(running_checksum))
        else $error("checksum changed without a write");

    AST_LOW_READ_DATA: assert property (
        rd_sum_low_next && !wr_low && !wr_in |-> hrdata[7:0] == running_checksum[7:0])
        else $error("low checksum read returned the wrong byte");

    AST_HIGH_READ_DATA: assert property (
        rd_sum_high_next |-> hrdata == {`CRC_ZERO_UPPER, running_checksum[15:8]})
        else $error("high checksum read returned the wrong byte");

    AST_INPUT_READ_DATA: assert property (
        rd_in_next |-> hrdata == {`CRC_ZERO_UPPER, crc_byte_input})
        else $error("input register read did not return the last byte");

    AST_GEN_READ_DATA: assert property (
        rd_gen_pending |-> hrdata[`CRC_GEN_SEL_BIT] == (generator_choice == GEN_CRC16))
        else $error("select bit read back differs from the generator in force");

    AST_UNMAPPED_READ_ZERO: assert property (
        rd_none_next |-> hrdata == `CRC_ZERO_WORD)
        else $error("read of an unmapped address was not zero");

    AST_ALWAYS_READY: assert property (
        hreadyout && hresp == `CRC_HRESP_OKAY)
        else $error("slave inserted a wait state or an error response");

    // A low clock enable must hold the checksum, input and select registers, read data included
    AST_FROZEN_STATE: assert property (
        !clk_en |=> $stable(running_checksum) && $stable(crc_byte_input)
                    && $stable(generator_choice) && $stable(hrdata))
        else $error("state moved while the clock enable was low");

    AST_INPUT_HOLDS: assert property (
        !wr_in |=> $stable(crc_byte_input))
        else $error("input register changed without a byte write");

    AST_GEN_HOLDS: assert property (
        !wr_gen |=> $stable(generator_choice))
        else $error("generator select changed without a select write");

    // The non-pipelined master reads one cycle after the write's data phase
    AST_READ_AFTER_FOLD: assert property (
        wr_in ##1 (clk_en && read_accept && read_sel == SEL_LOW && !(wr_in || wr_low || wr_high))
        |=> hrdata == {`CRC_ZERO_UPPER, $past(running_checksum[7:0])})
        else $error("read right after a byte write missed the new checksum");

    COV_FOLD_CCITT: cover property (
        wr_in && generator_choice == GEN_CCITT);

    COV_FOLD_CRC16: cover property (
        wr_in && generator_choice == GEN_CRC16);

    COV_TWO_BYTES: cover property (
        wr_in ##[1:4] wr_in);

    COV_READ_BEHIND_WRITE: cover property (
        wr_in && read_accept && read_sel == SEL_HIGH);

    COV_FROZEN_ACCESS: cover property (
        !clk_en && hsel && htrans[1]);

endmodule

// File: test_byte_crc16_generator.sv
/*
 * Self-checking testbench for byte_crc16_generator: register access over AHB-Lite,
 * byte folds against a bench model, direct checksum loads, refused accesses.
 * Assumes zero-wait answers as handed over, and hready tied back to hreadyout.
 */
`timescale 1ns/100ps
`include "crc_cfg.svh"

`define TB_CHECK(got, exp) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) \
        begin \
            miscompares++; \
            $display("Error at %0t ns: got %h expected %h", $time, (got), (exp)); \
        end \
    end

module test_byte_crc16_generator
    import crc_pkg::*;
;
    logic        clk_sys;
    logic        resetn;
    logic        clk_en;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    int          miscompares;
    int          total_checks;
    logic [31:0] rng_state;
    logic [31:0] r;
    logic [15:0] exp_sum;
    logic        exp_gen;
    logic [7:0]  seq_in [4];
    logic [15:0] seq_exp [2][4];

    byte_crc16_generator DUT (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .clk_en    (clk_en),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hreadyout),
        .hrdata    (hrdata),
        .hreadyout (hreadyout),
        .hresp     (hresp)
    );

    always #20 clk_sys = ~clk_sys;

    function automatic logic [31:0] next_rand();
        rng_state = rng_state ^ (rng_state << 13);
        rng_state = rng_state ^ (rng_state >> 17);
        rng_state = rng_state ^ (rng_state << 5);
        return rng_state;
    endfunction

    // Bit-serial reference, kept apart from the design's combinational engine
    function automatic logic [15:0] model_fold(input logic [15:0] sum, input logic [7:0] data,
                                               input logic crc16);
        logic [15:0] t;
        logic        top;
        t = sum ^ {data, 8'h00};
        for (int i = 0; i < 8; i++)
        begin
            top = t[15];
            t = {t[14:0], 1'b0};
            if (top)
                t = t ^ (crc16 ? `CRC_GENERATOR_CHOICE_CRC16 : `CRC_GENERATOR_CHOICE_CCITT);
        end
        return t;
    endfunction

    task automatic tally_and_finish();
        if (miscompares == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1 && n < 20)
        begin
            n++;
            @(posedge clk_sys);
        end
        if (n >= 20)
        begin
            miscompares++;
            tally_and_finish();
        end
    endtask

    task automatic bus_xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                            output logic [31:0] rdata);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= addr;
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wdata;
        wait_ready();
        rdata = hrdata;
        `TB_CHECK({hreadyout, hresp}, 2'b10)
    endtask

    task automatic wr(input logic [31:0] addr, input logic [31:0] data);
        logic [31:0] unused;
        bus_xfer(1'b1, addr, data, unused);
    endtask

    task automatic rd_chk(input logic [31:0] addr, input logic [31:0] exp);
        logic [31:0] got;
        bus_xfer(1'b0, addr, 32'h0000_0000, got);
        `TB_CHECK(got, exp)
    endtask

    task automatic sum_chk(input logic [15:0] s);
        rd_chk(`CRC_OFS_SUM_LOW, {24'h00_0000, s[7:0]});
        rd_chk(`CRC_OFS_SUM_HIGH, {24'h00_0000, s[15:8]});
    endtask

    // Folds one byte in the bench model and through the input register
    task automatic feed(input logic [7:0] b);
        wr(`CRC_OFS_BYTE_INPUT, {24'hA5_5A00, b});
        exp_sum = model_fold(exp_sum, b, exp_gen);
    endtask

    task automatic clear_sum();
        wr(`CRC_OFS_SUM_LOW, 32'h0000_0000);
        wr(`CRC_OFS_SUM_HIGH, 32'h0000_0000);
        exp_sum = 16'h0000;
    endtask

    initial
    begin
        clk_sys = 1'b0;
        resetn = 1'b0;
        clk_en = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        rng_state = 32'h0000_0032;
        miscompares = 0;
        total_checks = 0;
        seq_in = '{8'h78, 8'h56, 8'h34, 8'h12};
        seq_exp = '{'{16'hFF9F, 16'hBBC3, 16'hA367, 16'hD0FA},
                    '{16'h0110, 16'h91F1, 16'hF2DE, 16'h5C43}};
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        rd_chk(`CRC_OFS_GEN_SELECT, 32'h0000_0000);
        rd_chk(`CRC_OFS_BYTE_INPUT, 32'h0000_0000);
        sum_chk(16'h0000);
        rd_chk(32'h0000_0010, 32'h0000_0000);
        wr(`CRC_OFS_GEN_SELECT, 32'hFFFF_FFFF);
        rd_chk(`CRC_OFS_GEN_SELECT, 32'h0000_0001);
        wr(`CRC_OFS_GEN_SELECT, 32'h0000_00FE);
        rd_chk(`CRC_OFS_GEN_SELECT, 32'h0000_0000);
        for (int g = 0; g < 2; g++)
        begin
            exp_gen = g[0];
            wr(`CRC_OFS_GEN_SELECT, {31'h0, exp_gen});
            for (int b = 0; b < 8; b++)
            begin
                clear_sum();
                feed(b[7:0]);
                sum_chk(exp_sum);
            end
            // Fixed four-byte sequence guards the bench model itself
            clear_sum();
            for (int i = 0; i < 4; i++)
            begin
                feed(seq_in[i]);
                sum_chk(seq_exp[g][i]);
            end
        end
        rd_chk(`CRC_OFS_BYTE_INPUT, 32'h0000_0012);
        r = next_rand();
        wr(`CRC_OFS_SUM_LOW, r);
        wr(`CRC_OFS_SUM_HIGH, r >> 8);
        exp_sum = r[15:0];
        sum_chk(exp_sum);
        exp_gen = 1'b0;
        wr(`CRC_OFS_GEN_SELECT, 32'h0000_0000);
        sum_chk(exp_sum);
        feed(r[23:16]);
        sum_chk(exp_sum);
        wr(32'h0000_0010, 32'hFFFF_FFFF);
        sum_chk(exp_sum);
        rd_chk(`CRC_OFS_GEN_SELECT, 32'h0000_0000);
        // A write while frozen must not fold
        clk_en <= 1'b0;
        wr(`CRC_OFS_BYTE_INPUT, 32'h0000_00C3);
        clk_en <= 1'b1;
        sum_chk(exp_sum);
        rd_chk(`CRC_OFS_BYTE_INPUT, {24'h00_0000, r[23:16]});
        // Program words go low byte first, then high byte
        clear_sum();
        r = next_rand();
        feed(r[7:0]);
        feed(r[15:8]);
        sum_chk(exp_sum);
        for (int k = 0; k < 60; k++)
        begin
            r = next_rand();
            if (r[9:8] == 2'b00)
            begin
                exp_gen = r[10];
                wr(`CRC_OFS_GEN_SELECT, {r[31:1], exp_gen});
                rd_chk(`CRC_OFS_GEN_SELECT, {31'h0, exp_gen});
            end
            else
                feed(r[7:0]);
            sum_chk(exp_sum);
        end
        // Reset in mid-run brings every register back to zero
        resetn <= 1'b0;
        @(posedge clk_sys);
        resetn <= 1'b1;
        rd_chk(`CRC_OFS_GEN_SELECT, 32'h0000_0000);
        rd_chk(`CRC_OFS_BYTE_INPUT, 32'h0000_0000);
        sum_chk(16'h0000);
        tally_and_finish();
    end
endmodule
